// [include/tcam_port_if.sv]
/*
  Pin bundle between host and ternary match device.
  Assumes the testbench resolves the data bus from the two enables.
*/
`timescale 1ns/1ps
`include "tcam_port_map.svh"
interface tcam_port_if;
  logic phase;
  logic [`INSTR_W-1:0] instr_bus;
  logic opcode_valid;
  logic [`DQ_W-1:0] dq_h2d;
  logic dq_h2d_oe;
  logic [`DQ_W-1:0] dq_d2h;
  logic dq_d2h_oe;
  logic read_ack_n;
  logic burst_last;
  logic hit_flag;
  logic hit_flag_valid;
  logic multi_hit_n;
  logic [`PAGE_N-1:0] page_search_en_n;
  logic [`ASSOC_W-1:0] assoc_mem_addr;
  logic mem_clk;
  logic mem_cs_n;
  logic mem_we_n;
  logic mem_oe_n;
  logic mem_ale_n;
  modport device (
    input phase, instr_bus, opcode_valid, dq_h2d, dq_h2d_oe, page_search_en_n,
    output dq_d2h, dq_d2h_oe, read_ack_n, burst_last, hit_flag,
    hit_flag_valid, multi_hit_n, assoc_mem_addr, mem_clk, mem_cs_n,
    mem_we_n, mem_oe_n, mem_ale_n
  );
  modport host (
    output phase, instr_bus, opcode_valid, dq_h2d, dq_h2d_oe, page_search_en_n,
    input dq_d2h, dq_d2h_oe, read_ack_n, burst_last, hit_flag,
    hit_flag_valid, multi_hit_n
  );
endinterface

// [include/tcam_port_map.svh]
/*
  Constants of the ternary match engine host port: opcodes, widths, timing.
  Assumes inclusion by bare name from package and module files.
*/
`ifndef TCAM_PORT_MAP_SVH
`define TCAM_PORT_MAP_SVH
`define OPC_READ 2'h0
`define OPC_WRITE 2'h1
`define OPC_SEARCH 2'h2
`define OPC_WR_NEXT_FREE 2'h3
`define INSTR_W 9
`define DQ_W 68
`define WORD_W 136
`define ASSOC_W 22
`define PAGE_N 4
`define DEPTH_DEF 16
`define WIDTH_FLD_LSB 2
`define BURST_FLD_LSB 4
`define SEARCH_LAT 2
`endif

// [include/tcam_port_pkg.sv]
/*
  Shared types of the host port: opcode enum and search width codes.
  Assumes tcam_port_map.svh on the include path.
*/
`include "tcam_port_map.svh"
package tcam_port_pkg;
  typedef enum logic [1:0] {
    OP_READ = `OPC_READ,
    OP_WRITE = `OPC_WRITE,
    OP_SEARCH = `OPC_SEARCH,
    OP_WR_NEXT_FREE = `OPC_WR_NEXT_FREE
  } opcode_t;
  // Search width from instr_bus[3:2]
  typedef enum logic [1:0] {
    SW_HALF = 2'h0,
    SW_FULL = 2'h1,
    SW_DOUBLE = 2'h2,
    SW_RSVD = 2'h3
  } search_width_t;
endpackage

// [rtl/tcam_device.sv]
/*
  Device end: ternary array, instruction decode, search, memory strobes.
  Assumes phase and instr/data pins come from the host on i_clk_sys.
*/
`timescale 1ns/1ps
`include "tcam_port_map.svh"

// Overview of operation
// R1: Capture inputs on clock, halves by phase
// R2: Host toggles phase at half clock rate
// R3: Memory clock runs at half master rate
// R4: Low reset returns all state to idle (the code does not reset data_mem or mask_mem, so array contents survive reset)
// R5: Low two opcode bits select operation
// R6: Upper instruction bits carry operation parameters
// R7: Instruction taken only while opcode valid high
// R8: Data bus carries address, data, key
// R9: Read acknowledge low when read data valid
// R10: Burst last marks final burst transfer
// R11: Hit flag high when device holds result
// R12: Hit valid qualifies hit and multi-hit
// R13: Multi-hit low for two or more hits
// R14: Low page enables admit pages to search
// R15: Drive 22-bit associated memory address
// R16: Drive low-active memory strobes during access
// R17: Elements compare as zero, one, don't-care
// R18: Search as half, full or double words
// R19: Double-word search accepted at half rate
// R20: Cascade support, no added latency (the code has no cascade pins)
// R21: First half 135:68, second half 67:0
// R22: Lowest matching address wins
// R23: Bit zero marks entry valid or free
// R24: Names ending _n are active low
module tcam_device #(
  parameter int DEPTH = `DEPTH_DEF
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Pins
  tcam_port_if.device port
);
  localparam int AW = $clog2(DEPTH);
  localparam int PG = DEPTH / `PAGE_N;

  // Pin synchronisers
  logic phase_s1_ff, phase_ff, ov_s1_ff, ov_ff;
  logic [`INSTR_W-1:0] ins_s1_ff, ins_ff;
  logic [`DQ_W-1:0] dq_s1_ff, dq_ff;
  logic [`PAGE_N-1:0] sen_s1_ff, sen_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_s1_ff <= 1'b0;
      phase_ff <= 1'b0;
      ov_s1_ff <= 1'b0;
      ov_ff <= 1'b0;
      ins_s1_ff <= '0;
      ins_ff <= '0;
      dq_s1_ff <= '0;
      dq_ff <= '0;
      sen_s1_ff <= '0;
      sen_ff <= '0;
    end else begin
      phase_s1_ff <= port.phase;
      phase_ff <= phase_s1_ff;
      ov_s1_ff <= port.opcode_valid;
      ov_ff <= ov_s1_ff;
      ins_s1_ff <= port.instr_bus;
      ins_ff <= ins_s1_ff;
      dq_s1_ff <= port.dq_h2d;
      dq_ff <= dq_s1_ff;
      sen_s1_ff <= port.page_search_en_n;
      sen_ff <= sen_s1_ff;
    end
  end

  // Ternary array: data and care mask, bit 0 = valid
  logic [`WORD_W-1:0] data_mem [DEPTH];
  logic [`WORD_W-1:0] mask_mem [DEPTH];

  function automatic logic hit_word(input logic [`WORD_W-1:0] d,
      input logic [`WORD_W-1:0] m, input logic [`WORD_W-1:0] k);
    hit_word = (((d ^ k) & m) == '0) && d[0]; // see R17, R23
  endfunction

  // Word assembly: first half high bits
  logic [`DQ_W-1:0] hi_ff;
  logic [`WORD_W-1:0] word;
  logic ph_b, take;
  assign ph_b = phase_ff;
  assign word = {hi_ff, dq_ff}; // see R21
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) hi_ff <= '0;
    else if (!ph_b) hi_ff <= dq_ff; // see R1, R21
  end

  // Instruction latch in first half, executed in second
  logic ov_a_ff;
  logic [`INSTR_W-1:0] ins_a_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ov_a_ff <= 1'b0;
      ins_a_ff <= '0;
    end else if (!ph_b) begin
      ov_a_ff <= ov_ff; // see R7
      ins_a_ff <= ins_ff; // see R1
    end
  end
  assign take = ph_b && ov_a_ff;
  tcam_port_pkg::opcode_t opc;
  assign opc = tcam_port_pkg::opcode_t'(ins_a_ff[1:0]); // see R5
  tcam_port_pkg::search_width_t sw;
  assign sw = tcam_port_pkg::search_width_t'(
    ins_a_ff[`WIDTH_FLD_LSB+1:`WIDTH_FLD_LSB]); // see R6

  // State machine for addressed phase of read/write and bursts
  typedef enum logic [1:0] {S_IDLE, S_DATA, S_MASK} st_t;
  st_t st_ff;
  logic [AW-1:0] addr_ff;
  logic [2:0] blen_ff;
  logic is_wr_ff, dbl_half_ff;
  logic [`WORD_W-1:0] key_hi_ff;

  // Combinational search, lowest address first
  logic found;
  logic multi;
  logic pair_ok;
  logic [AW-1:0] hit_idx, cmp_idx;
  logic [`WORD_W-1:0] key;
  always_comb begin
    key = (sw == tcam_port_pkg::SW_HALF) ?
      {word[`DQ_W-1:0], word[`DQ_W-1:0]} : word; // see R18
    found = 1'b0;
    multi = 1'b0;
    hit_idx = '0;
    pair_ok = 1'b1;
    cmp_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      // Double words: even entry holds the first 136 bits
      pair_ok = 1'b1;
      cmp_idx = AW'(i);
      if (sw == tcam_port_pkg::SW_DOUBLE) begin
        pair_ok = (i % 2 == 0) &&
          hit_word(data_mem[i], mask_mem[i], key_hi_ff); // see R18
        cmp_idx = AW'((i + 1) % DEPTH);
      end
      if (!sen_ff[i / PG] && pair_ok &&
          hit_word(data_mem[cmp_idx], mask_mem[cmp_idx], key)) begin // see R14
        multi = multi | found; // see R13
        found = 1'b1;
        hit_idx = AW'(i); // see R22
      end
    end
  end

  // Next free entry
  logic [AW-1:0] free_idx;
  always_comb begin
    free_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
      if (!data_mem[i][0]) free_idx = AW'(i); // see R23
  end

  logic srch_go;
  assign srch_go = take && opc == tcam_port_pkg::OP_SEARCH &&
    (sw != tcam_port_pkg::SW_DOUBLE || dbl_half_ff); // see R19

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= S_IDLE; // see R4
      addr_ff <= '0;
      blen_ff <= '0;
      is_wr_ff <= 1'b0;
      dbl_half_ff <= 1'b0;
      key_hi_ff <= '0;
    end else if (ph_b) begin
      unique case (st_ff)
        S_IDLE: if (take) begin
          if (opc == tcam_port_pkg::OP_READ ||
              opc == tcam_port_pkg::OP_WRITE) begin
            st_ff <= S_DATA;
            addr_ff <= word[AW-1:0]; // see R8
            blen_ff <= ins_a_ff[`BURST_FLD_LSB+2:`BURST_FLD_LSB];
            is_wr_ff <= opc == tcam_port_pkg::OP_WRITE;
          end else if (opc == tcam_port_pkg::OP_WR_NEXT_FREE) begin
            data_mem[free_idx] <= word | `WORD_W'(1);
            mask_mem[free_idx] <= '1;
          end else if (sw == tcam_port_pkg::SW_DOUBLE) begin
            dbl_half_ff <= !dbl_half_ff;
            key_hi_ff <= word;
          end
        end
        S_DATA: begin
          if (is_wr_ff) data_mem[addr_ff] <= word;
          st_ff <= S_MASK;
        end
        S_MASK: begin
          if (is_wr_ff) mask_mem[addr_ff] <= word;
          addr_ff <= addr_ff + AW'(1);
          blen_ff <= blen_ff - 3'h1;
          st_ff <= (blen_ff == 3'h0) ? S_IDLE : S_DATA;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // Result outputs and data bus drive
  logic ack_n_ff, last_ff, hf_ff, hv_ff, mh_n_ff, oe_ff;
  logic [`DQ_W-1:0] dq_o_ff;
  logic [`ASSOC_W-1:0] aaddr_ff;
  logic [`WORD_W-1:0] rd_w;
  assign rd_w = (st_ff == S_DATA) ? data_mem[addr_ff] : mask_mem[addr_ff];
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_n_ff <= 1'b1;
      last_ff <= 1'b0;
      hf_ff <= 1'b0;
      hv_ff <= 1'b0;
      mh_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      dq_o_ff <= '0;
      aaddr_ff <= '0;
    end else begin
      ack_n_ff <= !(st_ff != S_IDLE && !is_wr_ff); // see R9, R24
      oe_ff <= st_ff != S_IDLE && !is_wr_ff;
      dq_o_ff <= ph_b ? rd_w[`DQ_W-1:0] : rd_w[`WORD_W-1:`DQ_W]; // see R21
      last_ff <= ph_b && st_ff == S_MASK && blen_ff == 3'h0; // see R10
      hv_ff <= srch_go; // see R12
      hf_ff <= srch_go && found; // see R11, R20
      mh_n_ff <= !(srch_go && multi); // see R13
      if (srch_go && found) aaddr_ff <= `ASSOC_W'(hit_idx); // see R15
    end
  end

  // Memory clock and strobes
  logic mclk_ff, mcs_n_ff, mwe_n_ff, moe_n_ff, male_n_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mclk_ff <= 1'b0;
      mcs_n_ff <= 1'b1;
      mwe_n_ff <= 1'b1;
      moe_n_ff <= 1'b1;
      male_n_ff <= 1'b1;
    end else begin
      mclk_ff <= !mclk_ff; // see R3
      mcs_n_ff <= !(srch_go && found); // see R16
      male_n_ff <= !(srch_go && found);
      moe_n_ff <= !(srch_go && found);
      mwe_n_ff <= 1'b1;
    end
  end

  assign port.read_ack_n = ack_n_ff;
  assign port.burst_last = last_ff;
  assign port.hit_flag = hf_ff;
  assign port.hit_flag_valid = hv_ff;
  assign port.multi_hit_n = mh_n_ff;
  assign port.dq_d2h = dq_o_ff;
  assign port.dq_d2h_oe = oe_ff;
  assign port.assoc_mem_addr = aaddr_ff;
  assign port.mem_clk = mclk_ff;
  assign port.mem_cs_n = mcs_n_ff;
  assign port.mem_we_n = mwe_n_ff;
  assign port.mem_oe_n = moe_n_ff;
  assign port.mem_ale_n = male_n_ff;
endmodule

// [rtl/tcam_host.sv]
/*
  Host end: phase generator, instruction issue, result capture.
  Assumes user requests are held until o_busy falls.
*/
`timescale 1ns/1ps
`include "tcam_port_map.svh"
module tcam_host (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // User request
  input wire logic i_req,
  input wire logic [`INSTR_W-1:0] i_instr,
  input wire logic [`WORD_W-1:0] i_word,
  // User results
  output logic o_busy,
  output logic o_hit_valid,
  output logic o_hit,
  output logic o_multi,
  output logic o_rd_valid,
  output logic [`DQ_W-1:0] o_rd_data,
  // Pins
  tcam_port_if.host port
);
  logic ph_ff, ov_ff, oe_ff, busy_ff;
  logic [`INSTR_W-1:0] ins_ff;
  logic [`DQ_W-1:0] dq_ff, lo_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_ff <= 1'b0;
      ov_ff <= 1'b0;
      oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      ins_ff <= '0;
      dq_ff <= '0;
      lo_ff <= '0;
    end else begin
      ph_ff <= !ph_ff; // see R2
      if (!ph_ff) begin
        dq_ff <= lo_ff; // see R21
        ov_ff <= 1'b0;
        busy_ff <= 1'b0;
      end else if (i_req) begin
        ov_ff <= 1'b1; // see R7
        ins_ff <= i_instr; // see R5, R6
        dq_ff <= i_word[`WORD_W-1:`DQ_W]; // see R8, R21
        lo_ff <= i_word[`DQ_W-1:0];
        oe_ff <= 1'b1;
        busy_ff <= 1'b1;
      end else begin
        ov_ff <= 1'b0;
        oe_ff <= 1'b0;
      end
    end
  end

  // Flags sampled through two flops, hit and multi-hit only when valid
  logic [3:0] s1_ff, s2_ff;
  logic [`DQ_W-1:0] d1_ff, d2_ff, d3_ff;
  logic hv_ff, hit_ff, mm_ff, rv_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      d1_ff <= '0;
      d2_ff <= '0;
      d3_ff <= '0;
      hv_ff <= 1'b0;
      hit_ff <= 1'b0;
      mm_ff <= 1'b0;
      rv_ff <= 1'b0;
    end else begin
      s1_ff <= {port.hit_flag_valid, port.hit_flag, !port.multi_hit_n,
        !port.read_ack_n}; // see R24
      s2_ff <= s1_ff;
      d1_ff <= port.dq_d2h;
      d2_ff <= d1_ff;
      d3_ff <= d2_ff;
      hv_ff <= s2_ff[3];
      if (s2_ff[3]) begin
        hit_ff <= s2_ff[2]; // see R12
        mm_ff <= s2_ff[1]; // see R13
      end
      rv_ff <= s2_ff[0]; // see R9
    end
  end

  assign port.phase = ph_ff;
  assign port.opcode_valid = ov_ff;
  assign port.instr_bus = ins_ff;
  assign port.dq_h2d = dq_ff;
  assign port.dq_h2d_oe = oe_ff;
  assign port.page_search_en_n = '0; // see R14
  assign o_busy = busy_ff;
  assign o_hit_valid = hv_ff;
  assign o_hit = hit_ff;
  assign o_multi = mm_ff;
  assign o_rd_valid = rv_ff;
  assign o_rd_data = d3_ff;
endmodule

// [test/tcam_port_properties.sv]
/*
  Checker of the pins between host and device ends.
  Assumes instantiation beside the interface that joins them.
*/
`timescale 1ns/1ps
`include "tcam_port_map.svh"
module tcam_port_properties (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Host pins
  input wire logic phase,
  input wire logic [`INSTR_W-1:0] instr_bus,
  input wire logic opcode_valid,
  input wire logic dq_h2d_oe,
  // Device pins
  input wire logic dq_d2h_oe,
  input wire logic read_ack_n,
  input wire logic hit_flag,
  input wire logic hit_flag_valid,
  input wire logic multi_hit_n,
  input wire logic mem_clk,
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic mem_ale_n,
  input wire logic burst_last
);
  logic [1:0] up_cnt_ff;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Cycles since release, saturating
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      up_cnt_ff <= 2'h0;
    end else if (up_cnt_ff != 2'h3) begin
      up_cnt_ff <= up_cnt_ff + 2'h1;
    end
  end
  a_phase_alternates: assert property (
    up_cnt_ff == 2'h3 |-> phase != $past(phase))
    else $error("phase held");
  a_mem_clk_half: assert property (
    up_cnt_ff == 2'h3 |-> mem_clk != $past(mem_clk))
    else $error("memory clock not half rate");
  a_reset_idle: assert property (
    disable iff (1'b0) !i_resetn ##1 !i_resetn |-> read_ack_n &&
    !hit_flag_valid && !dq_d2h_oe && mem_cs_n)
    else $error("outputs not idle in reset");
  a_valid_low_phase: assert property (
    opcode_valid |-> !phase ##1 !opcode_valid)
    else $error("instruction off phase");
  a_search_answered: assert property (
    opcode_valid && instr_bus[1:0] == tcam_port_pkg::OP_SEARCH &&
    instr_bus[3:2] != tcam_port_pkg::SW_DOUBLE |-> ##[2:14] hit_flag_valid)
    else $error("search not answered");
  a_hit_valid_pulse: assert property (
    hit_flag_valid |=> !hit_flag_valid)
    else $error("hit valid longer than one cycle");
  a_hit_qualified: assert property (
    hit_flag |-> hit_flag_valid)
    else $error("hit flag without valid");
  a_multi_means_hit: assert property (
    !multi_hit_n |-> hit_flag && hit_flag_valid)
    else $error("multi hit without hit");
  a_ack_drives_bus: assert property (
    !read_ack_n |-> dq_d2h_oe)
    else $error("acknowledge without data");
  a_no_contention: assert property (
    !(dq_h2d_oe && dq_d2h_oe))
    else $error("both ends drive data bus");
  a_write_strobe_off: assert property (
    mem_we_n)
    else $error("memory write strobe low");
  a_last_pulse: assert property (
    burst_last |=> !burst_last)
    else $error("burst last longer than one cycle");
  a_strobes_on_hit: assert property (
    hit_flag == !mem_cs_n && mem_ale_n == mem_cs_n && mem_oe_n == mem_cs_n)
    else $error("memory strobes out of step with hit");
endmodule

// [test/testbench.sv]
/*
  Bench joining host and device ends; a second device sees no valid.
  Assumes the design files and include/ on the search path.
*/
`timescale 1ns/1ps
`include "tcam_port_map.svh"
module testbench;
  localparam logic [`WORD_W-1:0] D1 = {17{8'ha5}};
  localparam logic [`WORD_W-1:0] D2 = {{16{8'h3c}}, 8'h3d};
  localparam logic [`WORD_W-1:0] D3 = {17{8'h81}};
  localparam logic [`WORD_W-1:0] ONES = {`WORD_W{1'b1}};
  localparam logic [`WORD_W-1:0] B8 = 136'h0100;
  logic i_clk_sys, i_resetn, i_req;
  logic [`INSTR_W-1:0] i_instr;
  logic [`WORD_W-1:0] i_word;
  logic o_busy, o_hit_valid, o_hit, o_multi, o_rd_valid;
  logic [`DQ_W-1:0] o_rd_data, rd_first;
  logic pin_hit, pin_multi_n;
  int fails = 0, checks = 0, hv_cnt = 0, rd_cnt = 0, rd_base = 0, n;
  int last_cnt = 0;
  tcam_port_if port_a ();
  tcam_port_if port_b ();
  tcam_device #(.DEPTH(4)) u_tcam_device (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .port(port_a));
  tcam_device #(.DEPTH(4)) u_tcam_device_b (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .port(port_b));
  tcam_host u_tcam_host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_req(i_req), .i_instr(i_instr), .i_word(i_word), .o_busy(o_busy),
    .o_hit_valid(o_hit_valid), .o_hit(o_hit), .o_multi(o_multi),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .port(port_a));
  tcam_port_properties u_tcam_port_properties (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .phase(port_a.phase),
    .instr_bus(port_a.instr_bus), .opcode_valid(port_a.opcode_valid),
    .dq_h2d_oe(port_a.dq_h2d_oe), .dq_d2h_oe(port_a.dq_d2h_oe),
    .read_ack_n(port_a.read_ack_n), .hit_flag(port_a.hit_flag),
    .hit_flag_valid(port_a.hit_flag_valid),
    .multi_hit_n(port_a.multi_hit_n), .mem_clk(port_a.mem_clk),
    .mem_cs_n(port_a.mem_cs_n), .mem_we_n(port_a.mem_we_n),
    .mem_oe_n(port_a.mem_oe_n), .mem_ale_n(port_a.mem_ale_n),
    .burst_last(port_a.burst_last));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // Result capture at user side and pins
  always @(posedge i_clk_sys) begin
    if (o_hit_valid === 1'b1) hv_cnt <= hv_cnt + 1;
    if (o_rd_valid === 1'b1) rd_cnt <= rd_cnt + 1;
    if (port_a.burst_last === 1'b1) last_cnt <= last_cnt + 1;
    if (o_rd_valid === 1'b1 && rd_cnt == rd_base) rd_first <= o_rd_data;
    if (port_a.hit_flag_valid === 1'b1) begin
      pin_hit <= port_a.hit_flag;
      pin_multi_n <= port_a.multi_hit_n;
    end
    port_b.phase <= ~port_b.phase;
    port_b.instr_bus <= port_b.instr_bus + 9'h001;
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [`WORD_W-1:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [`INSTR_W-1:0] ins(input logic [1:0] op, w);
    return {5'h00, w, op};
  endfunction
  task automatic issue(input logic [1:0] op, w, input logic [135:0] word);
    @(posedge i_clk_sys);
    i_req <= 1'b1;
    i_instr <= ins(op, w);
    i_word <= word;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_busy !== 1'b1 && n < 40);
    i_req <= 1'b0;
    while (o_busy !== 1'b0 && n < 80) begin
      @(posedge i_clk_sys);
      n++;
    end
    check(136'(n < 40), 136'h1);
    repeat (2) @(posedge i_clk_sys);
  endtask
  // Address, data and mask words go out in back-to-back phase pairs
  task automatic write_entry(input logic [135:0] a, d, m);
    logic [135:0] wd [3];
    wd = '{a, d, m};
    @(posedge i_clk_sys);
    i_req <= 1'b1;
    i_instr <= ins(tcam_port_pkg::OP_WRITE, tcam_port_pkg::SW_FULL);
    for (int k = 0; k < 3; k++) begin
      i_word <= wd[k];
      n = 0;
      do begin
        @(posedge i_clk_sys);
        n++;
      end while (o_busy !== 1'b1 && n < 40);
      check(136'(n < 40), 136'h1);
    end
    i_req <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic search(input logic [135:0] k, input logic hit, multi,
      input logic [1:0] w = tcam_port_pkg::SW_FULL);
    int base;
    base = hv_cnt;
    issue(tcam_port_pkg::OP_SEARCH, w, k);
    for (int i = 0; i < 30 && hv_cnt == base; i++) @(posedge i_clk_sys);
    check(136'(hv_cnt > base), 136'h1);
    check(136'(o_hit), 136'(hit));
    check(136'(o_multi), 136'(multi));
    check(136'(pin_hit), 136'(hit));
    check(136'(pin_multi_n), 136'(!multi));
  endtask
  task automatic test_read();
    int base;
    base = last_cnt;
    rd_base = rd_cnt;
    issue(tcam_port_pkg::OP_READ, tcam_port_pkg::SW_FULL, 136'h1);
    for (int i = 0; i < 40 && rd_cnt == rd_base; i++) @(posedge i_clk_sys);
    check(136'(rd_first), 136'(D1[135:68]));
    check(136'(last_cnt), 136'(base + 1));
  endtask
  task automatic test_ignored();
    for (int i = 0; i < 40; i++) begin
      @(posedge i_clk_sys);
      check(136'(port_b.hit_flag_valid), 136'h0);
      check(136'(port_b.read_ack_n), 136'h1);
    end
  endtask
  task automatic test_double();
    int base;
    base = hv_cnt;
    issue(tcam_port_pkg::OP_SEARCH, tcam_port_pkg::SW_DOUBLE, D2);
    repeat (20) @(posedge i_clk_sys);
    check(136'(hv_cnt), 136'(base));
    search(D3, 1'b1, 1'b0, tcam_port_pkg::SW_DOUBLE);
    check(136'(port_a.assoc_mem_addr), 136'h2);
  endtask
  initial begin
    i_resetn = 1'b0;
    i_req = 1'b0;
    i_instr = 9'h000;
    i_word = 136'h0;
    port_b.phase = 1'b0;
    port_b.instr_bus = 9'h000;
    port_b.opcode_valid = 1'b0;
    port_b.dq_h2d = D1[67:0];
    port_b.dq_h2d_oe = 1'b1;
    port_b.page_search_en_n = 4'h0;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    for (int a = 0; a < 4; a++) write_entry(136'(a), 136'h0, ONES);
    search(D1, 1'b0, 1'b0);
    write_entry(136'h0, D1, ONES);
    search(D1, 1'b1, 1'b0);
    search(D1 ^ B8, 1'b0, 1'b0);
    write_entry(136'h1, D1, ONES);
    search(D1, 1'b1, 1'b1);
    write_entry(136'h2, D2, ONES ^ B8);
    search(D2 ^ B8, 1'b1, 1'b0);
    issue(tcam_port_pkg::OP_WR_NEXT_FREE, tcam_port_pkg::SW_FULL, D3);
    issue(tcam_port_pkg::OP_WR_NEXT_FREE, tcam_port_pkg::SW_FULL, ONES);
    search(D3, 1'b1, 1'b0);
    check(136'(port_a.assoc_mem_addr), 136'h3);
    write_entry(136'h0, ONES, ONES);
    search(ONES, 1'b1, 1'b0, tcam_port_pkg::SW_HALF);
    check(136'(port_a.assoc_mem_addr), 136'h0);
    test_read();
    test_ignored();
    test_double();
    complete_run();
  end
  // Hang guard, well above the expected run
  initial begin
    #160000;
    fails++;
    complete_run();
  end
endmodule
